// ---- hw/thc_pkg.sv ----
`default_nettype none
package thc_pkg;
   localparam logic [15:0] THC_DIAG_IDLE = 16'h0000;
   localparam logic [15:0] THC_DIAG_ACTUATED = 16'h8000;
   localparam logic [15:0] THC_DIAG_INIT = 16'h8001;
   localparam logic [15:0] THC_DIAG_RELEASED = 16'h8004;
   localparam logic [15:0] THC_DIAG_FIRST_ONLY = 16'h8005;
   localparam logic [15:0] THC_DIAG_SECOND_ONLY = 16'h8006;
   localparam logic [15:0] THC_DIAG_FIRST_HELD = 16'h8007;
   localparam logic [15:0] THC_DIAG_SECOND_HELD = 16'h8008;
   localparam logic [15:0] THC_DIAG_ERR_FIRST = 16'hC001;
   localparam logic [15:0] THC_DIAG_ERR_SECOND = 16'hC002;
   localparam logic [15:0] THC_DIAG_ERR_BOTH = 16'hC003;

   typedef enum logic [3:0] {
      THC_IDLE, THC_INIT, THC_RELEASED, THC_FIRST_ONLY, THC_SECOND_ONLY, THC_ACTUATED,
      THC_FIRST_HELD, THC_SECOND_HELD, THC_ERR_FIRST, THC_ERR_SECOND, THC_ERR_BOTH
   } thc_state_t;

   typedef struct packed {
      logic ready;
      logic error;
      logic safety_release_out;
      logic [15:0] diag_state_word;
   } thc_status_t;
endpackage
`default_nettype wire

// ---- hw/thc_decode.sv ----
`default_nettype none
module thc_decode (
   input wire thc_pkg::thc_state_t i_state,
   output var thc_pkg::thc_status_t o_status
);
   import thc_pkg::*;
   always_comb begin
      o_status = '{ready: 1'b1, error: 1'b0, safety_release_out: 1'b0, diag_state_word: THC_DIAG_IDLE};
      case (i_state)
         THC_IDLE: o_status.ready = 1'b0;
         THC_INIT: o_status.diag_state_word = THC_DIAG_INIT;
         THC_RELEASED: o_status.diag_state_word = THC_DIAG_RELEASED;
         THC_FIRST_ONLY: o_status.diag_state_word = THC_DIAG_FIRST_ONLY;
         THC_SECOND_ONLY: o_status.diag_state_word = THC_DIAG_SECOND_ONLY;
         THC_ACTUATED: begin
            o_status.diag_state_word = THC_DIAG_ACTUATED;
            o_status.safety_release_out = 1'b1;
         end
         THC_FIRST_HELD: o_status.diag_state_word = THC_DIAG_FIRST_HELD;
         THC_SECOND_HELD: o_status.diag_state_word = THC_DIAG_SECOND_HELD;
         THC_ERR_FIRST: begin
            o_status.diag_state_word = THC_DIAG_ERR_FIRST;
            o_status.error = 1'b1;
         end
         THC_ERR_SECOND: begin
            o_status.diag_state_word = THC_DIAG_ERR_SECOND;
            o_status.error = 1'b1;
         end
         THC_ERR_BOTH: begin
            o_status.diag_state_word = THC_DIAG_ERR_BOTH;
            o_status.error = 1'b1;
         end
         default: o_status.ready = 1'b0;
      endcase
   end
endmodule // thc_decode
`default_nettype wire

// ---- hw/thc_two_hand_block.sv ----
// How it works
// - the safety output is high only with both buttons high, no error and a correct two-hand sequence.
// - the safety output is low whenever a button is released or the sequence was wrong.
// - once the output has dropped, both buttons must be released before it can rise again.
// - activation low returns every state to idle, above all other transitions.
// - a button already pressed at activation is an error and enters an error state.
// - in every error state the safety output is held low.
// - an error is left and its flag cleared once both buttons are seen low.
// - only the first button pressed at activation reports C001 with ready and error high.
// - only the second button pressed at activation reports C002 with ready and error high.
// - both buttons pressed at activation report C003 with ready and error high.
// - 8000 is reported with the output high, 8001 in the initial active state, both with ready.
// - 8004 with no button, 8005 with only the first, 8006 with only the second, output low.
// - after the output drops, 8007 while only the first stays high, 8008 while only the second does.
`default_nettype none
module thc_two_hand_block (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_activate,
   input wire logic i_first_button_in,
   input wire logic i_second_button_in,
   output logic o_ready,
   output logic o_error,
   output logic o_safety_release_out,
   output logic [15:0] o_diag_state_word
);
   import thc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   thc_state_t state_reg;
   thc_state_t state_next;
   thc_status_t status_next;
   logic b1;
   logic b2;
   assign b1 = i_first_button_in;
   assign b2 = i_second_button_in;

   always_comb begin
      state_next = state_reg;
      if (!i_activate) begin
         state_next = THC_IDLE;
      end else begin
         case (state_reg)
            THC_IDLE: state_next = THC_INIT;
            THC_INIT: begin
               // buttons already pressed when activated are illegal
               if (b1 && b2) state_next = THC_ERR_BOTH;
               else if (b1) state_next = THC_ERR_FIRST;
               else if (b2) state_next = THC_ERR_SECOND;
               else state_next = THC_RELEASED;
            end
            THC_ERR_FIRST, THC_ERR_SECOND, THC_ERR_BOTH: begin
               if (!b1 && !b2) state_next = THC_RELEASED;
            end
            THC_RELEASED, THC_FIRST_ONLY, THC_SECOND_ONLY: begin
               if (b1 && b2) state_next = THC_ACTUATED;
               else if (b1) state_next = THC_FIRST_ONLY;
               else if (b2) state_next = THC_SECOND_ONLY;
               else state_next = THC_RELEASED;
            end
            THC_ACTUATED: begin
               if (!b1 && !b2) state_next = THC_RELEASED;
               else if (!b2) state_next = THC_FIRST_HELD;
               else if (!b1) state_next = THC_SECOND_HELD;
            end
            THC_FIRST_HELD, THC_SECOND_HELD: begin
               // no path back to actuated without a full release
               if (!b1 && !b2) state_next = THC_RELEASED;
               else if (b1 && !b2) state_next = THC_FIRST_HELD;
               else if (!b1 && b2) state_next = THC_SECOND_HELD;
            end
            default: state_next = THC_IDLE;
         endcase
      end
   end

   // outputs decoded from the next state so they leave flops in step with it
   thc_decode u_decode (
      .i_state(state_next),
      .o_status(status_next)
   );

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= THC_IDLE;
         o_ready <= 1'b0;
         o_error <= 1'b0;
         o_safety_release_out <= 1'b0;
         o_diag_state_word <= THC_DIAG_IDLE;
      end else begin
         state_reg <= state_next;
         o_ready <= status_next.ready;
         o_error <= status_next.error;
         o_safety_release_out <= status_next.safety_release_out;
         o_diag_state_word <= status_next.diag_state_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_OUT_NEEDS_BUTTONS: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(o_safety_release_out) |-> $past(b1) && $past(b2) && !o_error)
      else $error("safety output rose without both buttons");
   AST_OUT_DROPS: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_safety_release_out && (!b1 || !b2) |=> !o_safety_release_out)
      else $error("safety output not dropped on release");
   // a fall into the released code already met the rule, so only held or idle falls count
   AST_REARM_NEEDS_RELEASE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $fell(o_safety_release_out) && o_diag_state_word != THC_DIAG_RELEASED && i_activate && (b1 || b2)
      ##1 (i_activate && b1 && b2) |=> !o_safety_release_out)
      else $error("safety output rearmed without full release");
   AST_DEACTIVATE_IDLE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !i_activate |=> !o_ready && o_diag_state_word == THC_DIAG_IDLE && !o_safety_release_out)
      else $error("not idle after deactivation");
   AST_ERR_SAFE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_error |-> !o_safety_release_out && o_diag_state_word[15:14] == 2'b11)
      else $error("error with output high");
   AST_ERR_CLEAR: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_error && i_activate && !b1 && !b2 |=> !o_error && o_diag_state_word == THC_DIAG_RELEASED)
      else $error("error not cleared on release");
   AST_ACT_ERR_BOTH: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(i_activate) && b1 && b2 ##1 (i_activate && b1 && b2)
      |=> o_diag_state_word == THC_DIAG_ERR_BOTH && o_error)
      else $error("both-pressed activation not flagged");
   AST_ACT_ERR_FIRST: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(i_activate) ##1 (i_activate && b1 && !b2) |=> o_diag_state_word == THC_DIAG_ERR_FIRST && o_ready)
      else $error("first-pressed activation not flagged");
   AST_READY: assert property (@(posedge i_clock) disable iff (!i_nrst)
      i_activate |=> o_ready)
      else $error("ready low while active");
   AST_ACT_ERR_SECOND: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(i_activate) ##1 (i_activate && !b1 && b2)
      |=> o_diag_state_word == THC_DIAG_ERR_SECOND && o_ready && o_error && !o_safety_release_out)
      else $error("second-pressed activation not flagged");
   AST_ACT_ERR_ANY: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(i_activate) ##1 (i_activate && (b1 || b2))
      |=> o_error && !o_safety_release_out)
      else $error("pressed button at activation not treated as error");
   AST_ERR_STAYS: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_error && i_activate && (b1 || b2)
      |=> o_error && !o_safety_release_out)
      else $error("error left while a button is still held");
   AST_ERR_READY: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_error
      |-> o_ready)
      else $error("error reported without ready");
   AST_ERR_BOTH_RELEASE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_diag_state_word == THC_DIAG_ERR_BOTH && i_activate && !b1 && !b2
      |=> o_diag_state_word == THC_DIAG_RELEASED)
      else $error("release after both-pressed error not direct");

   ////////////////////////////////////////////////////////////////////////////
   // codes and levels, read only from the registered outputs
   AST_RESET_IDLE: assert property (@(posedge i_clock)
      !i_nrst |=> !o_ready && !o_error && !o_safety_release_out
      && o_diag_state_word == THC_DIAG_IDLE)
      else $error("outputs not cleared by reset");
   AST_IDLE_QUIET: assert property (@(posedge i_clock) disable iff (!i_nrst)
      !o_ready
      |-> o_diag_state_word == THC_DIAG_IDLE && !o_error && !o_safety_release_out)
      else $error("inactive outputs not quiet");
   AST_INIT_CODE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(i_activate)
      |=> o_diag_state_word == THC_DIAG_INIT && o_ready && !o_safety_release_out)
      else $error("init code not shown after activation");
   AST_ACTUATED_CODE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_safety_release_out
      |-> o_diag_state_word == THC_DIAG_ACTUATED && o_ready && !o_error)
      else $error("output high outside the actuated code");
   AST_OUT_NEEDS_BOTH_NOW: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_safety_release_out
      |-> $past(b1) && $past(b2))
      else $error("output high although a button was up");
   AST_OUT_HOLDS: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_safety_release_out && i_activate && b1 && b2
      |=> o_safety_release_out)
      else $error("output dropped with both buttons held");
   AST_BOTH_LOW_RELEASED: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_ready && i_activate && !b1 && !b2
      |=> o_diag_state_word == THC_DIAG_RELEASED && !o_error && !o_safety_release_out)
      else $error("both buttons up without released code");
   AST_FIRST_ONLY_CODE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      i_activate && b1 && !b2 && (o_diag_state_word == THC_DIAG_RELEASED
      || o_diag_state_word == THC_DIAG_FIRST_ONLY || o_diag_state_word == THC_DIAG_SECOND_ONLY)
      |=> o_diag_state_word == THC_DIAG_FIRST_ONLY && !o_safety_release_out)
      else $error("first button alone not reported");
   AST_SECOND_ONLY_CODE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      i_activate && !b1 && b2 && (o_diag_state_word == THC_DIAG_RELEASED
      || o_diag_state_word == THC_DIAG_FIRST_ONLY || o_diag_state_word == THC_DIAG_SECOND_ONLY)
      |=> o_diag_state_word == THC_DIAG_SECOND_ONLY && !o_safety_release_out)
      else $error("second button alone not reported");
   AST_DROP_FIRST_HELD: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_safety_release_out && i_activate && b1 && !b2
      |=> o_diag_state_word == THC_DIAG_FIRST_HELD && !o_safety_release_out)
      else $error("drop with first held not reported");
   AST_DROP_SECOND_HELD: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_safety_release_out && i_activate && !b1 && b2
      |=> o_diag_state_word == THC_DIAG_SECOND_HELD && !o_safety_release_out)
      else $error("drop with second held not reported");
   AST_HELD_NO_OUT: assert property (@(posedge i_clock) disable iff (!i_nrst)
      o_diag_state_word == THC_DIAG_FIRST_HELD || o_diag_state_word == THC_DIAG_SECOND_HELD
      |-> !o_safety_release_out && o_ready && !o_error)
      else $error("output high in a held code");

   ////////////////////////////////////////////////////////////////////////////
   // rearm watch kept apart from the state machine, so a shared slip cannot hide
   logic rearm_block_reg;
   logic rearm_block_next;

   always_comb begin
      rearm_block_next = rearm_block_reg;
      if (!i_activate || (!b1 && !b2)) begin
         rearm_block_next = 1'b0;
      end else if (o_safety_release_out) begin
         rearm_block_next = 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rearm_block_reg <= 1'b0;
      end else begin
         rearm_block_reg <= rearm_block_next;
      end
   end

   AST_REARM_BLOCKED: assert property (@(posedge i_clock) disable iff (!i_nrst)
      rearm_block_reg && !o_safety_release_out && i_activate && (b1 || b2)
      |=> !o_safety_release_out)
      else $error("output rose before both buttons were released");
endmodule // thc_two_hand_block
`default_nettype wire

// ---- verif/thc_button_pair.sv ----
`default_nettype none
// two operator buttons; contacts follow the operator's hands directly, no debounce
module thc_button_pair (
   input wire logic i_press_first,
   input wire logic i_press_second,
   output logic o_first_button_in,
   output logic o_second_button_in
);
   timeunit 1ns;
   timeprecision 1ps;
   assign o_first_button_in = i_press_first;
   assign o_second_button_in = i_press_second;
endmodule // thc_button_pair
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb;
   import thc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic act = 1'b0;
   logic p1 = 1'b0;
   logic p2 = 1'b0;
   wire logic b1;
   wire logic b2;
   logic o_ready, o_error, o_safety_release_out;
   logic [15:0] o_diag_state_word;
   thc_status_t exp_q[$];
   thc_status_t pend;
   logic have_pend = 1'b0;
   int err_count = 0;
   int num_checks = 0;
   always #12.5 i_clock = ~i_clock;
   thc_button_pair hands_u (.i_press_first(p1), .i_press_second(p2), .o_first_button_in(b1),
      .o_second_button_in(b2));
   thc_two_hand_block dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_activate(act), .i_first_button_in(b1),
      .i_second_button_in(b2), .o_ready(o_ready), .o_error(o_error),
      .o_safety_release_out(o_safety_release_out), .o_diag_state_word(o_diag_state_word));
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (err_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // expectation is queued one edge later, when the design has sampled these inputs
   task automatic st(input logic a, input logic c1, input logic c2, input logic [15:0] code);
      thc_status_t e;
      e = {code != 16'h0000, code[15:14] == 2'b11, code == THC_DIAG_ACTUATED, code};
      @(posedge i_clock);
      act <= a;
      p1 <= c1;
      p2 <= c2;
      if (have_pend) exp_q.push_back(pend);
      pend = e;
      have_pend = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge i_clock) begin
      thc_status_t got;
      got = {o_ready, o_error, o_safety_release_out, o_diag_state_word};
      if (exp_q.size() > 0) begin
         num_checks++;
         if (got !== exp_q[0]) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp_q[0], got);
         end
         void'(exp_q.pop_front());
      end
   end
   initial begin
      #(300 * 25);
      err_count++;
      complete_run();
   end
   initial begin
      void'($urandom(32'hA7A7));
      repeat (5) @(posedge i_clock);
      i_nrst <= 1'b1;
      // buttons wiggle while inactive: nothing may leave idle
      repeat (6) st(1'b0, 1'($urandom), 1'($urandom), THC_DIAG_IDLE);
      st(1'b1, 1'b0, 1'b0, THC_DIAG_INIT);
      st(1'b1, 1'b0, 1'b0, THC_DIAG_RELEASED);
      st(1'b1, 1'b1, 1'b0, THC_DIAG_FIRST_ONLY);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_ACTUATED);
      st(1'b1, 1'b1, 1'b0, THC_DIAG_FIRST_HELD);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_FIRST_HELD);
      st(1'b1, 1'b0, 1'b0, THC_DIAG_RELEASED);
      st(1'b1, 1'b0, 1'b1, THC_DIAG_SECOND_ONLY);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_ACTUATED);
      st(1'b1, 1'b0, 1'b1, THC_DIAG_SECOND_HELD);
      st(1'b1, 1'b0, 1'b0, THC_DIAG_RELEASED);
      st(1'b1, 1'b1, 1'b0, THC_DIAG_FIRST_ONLY);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_ACTUATED);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_ACTUATED);
      st(1'b0, 1'b1, 1'b1, THC_DIAG_IDLE);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_INIT);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_ERR_BOTH);
      st(1'b1, 1'b1, 1'b1, THC_DIAG_ERR_BOTH);
      st(1'b1, 1'b0, 1'b0, THC_DIAG_RELEASED);
      st(1'b0, 1'b0, 1'b0, THC_DIAG_IDLE);
      st(1'b1, 1'b1, 1'b0, THC_DIAG_INIT);
      st(1'b1, 1'b1, 1'b0, THC_DIAG_ERR_FIRST);
      st(1'b0, 1'b1, 1'b0, THC_DIAG_IDLE);
      st(1'b1, 1'b0, 1'b1, THC_DIAG_INIT);
      st(1'b1, 1'b0, 1'b1, THC_DIAG_ERR_SECOND);
      st(1'b1, 1'b0, 1'b0, THC_DIAG_RELEASED);
      st(1'b0, 1'b0, 1'b0, THC_DIAG_IDLE);
      st(1'b0, 1'b0, 1'b0, THC_DIAG_IDLE);
      // last note is due once the design has sampled the last inputs
      @(posedge i_clock);
      exp_q.push_back(pend);
      repeat (3) @(posedge i_clock);
      complete_run();
   end
endmodule // tb
`default_nettype wire
